// ===== swa_map.svh
// Bit positions, reset value and address constants of the status word block
`ifndef SWA_MAP_SVH
`define SWA_MAP_SVH

`define SWA_PSW_RST 8'h00
`define SWA_CY_BIT 7
`define SWA_AC_BIT 6
`define SWA_F0_BIT 5
`define SWA_RS1_BIT 4
`define SWA_RS0_BIT 3
`define SWA_OV_BIT 2
`define SWA_RSV_BIT 1
`define SWA_P_BIT 0
`define SWA_PC_STEP 16'h0001
`define SWA_SFR_BIT 7
`define SWA_BANK_PAD 3'h0

`endif

// ===== swa_pkg.sv
// Types shared by the status word and operand address logic
package swa_pkg;

    typedef enum logic [2:0] {
        md_direct,
        md_indirect8,
        md_indirect16,
        md_register,
        md_implicit,
        md_immediate,
        md_indexed,
        md_case_jump
    } swa_mode_type;

    typedef enum logic [0:0] {
        st_idle,
        st_pointer
    } swa_state_type;

endpackage

// ===== swa_parity.sv
// Odd-count detector over a data word
`timescale 1ns/1ps
module swa_parity #(
    parameter int W = 8
) (
    input wire logic [W-1:0] data,
    output logic odd
);
    logic [W:0] chain;

    assign chain[0] = 1'b0;
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign chain[i+1] = chain[i] ^ data[i];
    end
    assign odd = chain[W];

endmodule

// ===== swa_idx_add.sv
// Base plus zero-extended index, wrapping at the base width
`timescale 1ns/1ps
module swa_idx_add #(
    parameter int AW = 16,
    parameter int DW = 8
) (
    input wire logic [AW-1:0] base,
    input wire logic [DW-1:0] index,
    output logic [AW-1:0] sum
);
    // Carry out of the top bit is dropped on purpose
    assign sum = base + {{(AW-DW){1'b0}}, index};

endmodule

// ===== swa_core.sv
// Program status word and operand address generation
`timescale 1ns/1ps
`include "swa_map.svh"

// How it works
// - Parity bit is one exactly when the accumulator has odd ones.
// - Parity bit zero is recomputed every enabled cycle, writes ignored.
// - Carry sits at bit seven, set by arithmetic or Boolean updates.
// - Half-carry sits at bit six, loaded from the arithmetic unit.
// - User flag at bit five changes only on software writes.
// - Bank select bits four and three are written by software.
// - Bank value times eight gives working register base in RAM.
// - Bank is taken from the status word when the instruction starts.
// - Overflow at bit two; bit one reserved and reads zero.
// - Direct mode uses the address byte; top half means SPECIAL_FUNCTION_REGISTER space.
// - Eight-bit indirect pointer comes from register zero, one, or stack.
// - Indirect reaches internal or external RAM; 16-bit uses data pointer.
// - Register mode picks one of eight bank registers from opcode bits.
// - Implicit opcodes flag their fixed register, no address byte used.
// - Immediate operand is fetched at program counter plus one.
// - Indexed mode only reads program memory, never writes.
// - Indexed address is data pointer or counter plus accumulator.
// - Case jump loads counter with data pointer plus accumulator.
module swa_core
    import swa_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [DW-1:0] acc,
    input wire logic sfr_wr_en,
    input wire logic [DW-1:0] sfr_wr_data,
    output logic [DW-1:0] program_status_word,
    input wire logic alu_flag_we,
    input wire logic alu_carry,
    input wire logic alu_half_carry,
    input wire logic alu_overflow,
    input wire logic bool_carry_we,
    input wire logic bool_carry,
    input wire logic instr_start,
    input wire swa_mode_type instr_mode,
    input wire logic [DW-1:0] opcode,
    input wire logic [DW-1:0] addr_byte,
    input wire logic ind_use_sp,
    input wire logic ind_external,
    input wire logic idx_base_pc,
    input wire logic operand_write,
    input wire logic [DW-1:0] stack_pointer,
    input wire logic [AW-1:0] data_pointer,
    input wire logic [AW-1:0] prog_counter,
    input wire logic [DW-1:0] ram_rd_data,
    output logic busy,
    output logic done,
    output logic [DW-1:0] iram_addr,
    output logic iram_sel,
    output logic sfr_sel,
    output logic [AW-1:0] xram_addr,
    output logic xram_sel,
    output logic [AW-1:0] code_addr,
    output logic code_rd,
    output logic oper_wr_en,
    output logic pc_load,
    output logic [AW-1:0] pc_next,
    output logic implicit_sel
);
    logic [DW-1:0] psw_ff;
    logic [DW-1:0] nxt_psw;
    logic acc_odd;
    logic [1:0] bank;
    logic [DW-1:0] bank_base;
    logic [AW-1:0] idx_base;
    logic [AW-1:0] idx_sum;

    swa_state_type state_ff;
    swa_state_type nxt_state;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [DW-1:0] iram_addr_ff, nxt_iram_addr;
    logic iram_sel_ff, nxt_iram_sel;
    logic sfr_sel_ff, nxt_sfr_sel;
    logic [AW-1:0] xram_addr_ff, nxt_xram_addr;
    logic xram_sel_ff, nxt_xram_sel;
    logic [AW-1:0] code_addr_ff, nxt_code_addr;
    logic code_rd_ff, nxt_code_rd;
    logic wr_ff, nxt_wr;
    logic ext_ff, nxt_ext;
    logic pc_load_ff, nxt_pc_load;
    logic [AW-1:0] pc_next_ff, nxt_pc_next;
    logic implicit_ff, nxt_implicit;

    swa_parity #(
        .W(DW)
    ) u_parity (
        .data(acc),
        .odd(acc_odd)
    );

    // Case jump always indexes off the data pointer
    assign idx_base = (instr_mode == md_indexed && idx_base_pc) ?
                      prog_counter : data_pointer;

    swa_idx_add #(
        .AW(AW),
        .DW(DW)
    ) u_idx_add (
        .base(idx_base),
        .index(acc),
        .sum(idx_sum)
    );

    assign bank = {psw_ff[`SWA_RS1_BIT], psw_ff[`SWA_RS0_BIT]};
    assign bank_base = {`SWA_BANK_PAD, bank, 3'h0};

    // Status word: hardware flag updates outrank a software write
    always_comb begin
        nxt_psw = psw_ff;
        if (sfr_wr_en) begin
            nxt_psw = sfr_wr_data;
        end
        if (alu_flag_we) begin
            nxt_psw[`SWA_CY_BIT] = alu_carry;
            nxt_psw[`SWA_AC_BIT] = alu_half_carry;
            nxt_psw[`SWA_OV_BIT] = alu_overflow;
        end
        if (bool_carry_we) begin
            nxt_psw[`SWA_CY_BIT] = bool_carry;
        end
        nxt_psw[`SWA_RSV_BIT] = 1'b0;
        nxt_psw[`SWA_P_BIT] = acc_odd;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            psw_ff <= `SWA_PSW_RST;
        end else if (ce) begin
            psw_ff <= nxt_psw;
        end
    end

    // Address sequencer; addresses and selects stand until the next instruction, done and pc_load pulse
    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_iram_addr = iram_addr_ff;
        nxt_iram_sel = iram_sel_ff;
        nxt_sfr_sel = sfr_sel_ff;
        nxt_xram_addr = xram_addr_ff;
        nxt_xram_sel = xram_sel_ff;
        nxt_code_addr = code_addr_ff;
        nxt_code_rd = code_rd_ff;
        nxt_wr = wr_ff;
        nxt_ext = ext_ff;
        nxt_pc_load = 1'b0;
        nxt_pc_next = pc_next_ff;
        nxt_implicit = implicit_ff;
        unique case (state_ff)
            st_idle: begin
                if (instr_start) begin
                    nxt_done = 1'b1;
                    nxt_iram_sel = 1'b0;
                    nxt_sfr_sel = 1'b0;
                    nxt_xram_sel = 1'b0;
                    nxt_code_rd = 1'b0;
                    nxt_implicit = 1'b0;
                    nxt_wr = operand_write;
                    nxt_ext = ind_external;
                    unique case (instr_mode)
                        md_direct: begin
                            nxt_iram_addr = addr_byte;
                            nxt_sfr_sel = addr_byte[`SWA_SFR_BIT];
                            nxt_iram_sel = !addr_byte[`SWA_SFR_BIT];
                        end
                        md_indirect8: begin
                            if (ind_use_sp) begin
                                nxt_iram_addr = stack_pointer;
                                nxt_iram_sel = !ind_external;
                                nxt_xram_addr = {8'h00, stack_pointer};
                                nxt_xram_sel = ind_external;
                            end else begin
                                // Pointer lives in bank register 0 or 1
                                nxt_iram_addr = {bank_base[7:1],
                                                 opcode[0]};
                                nxt_iram_sel = 1'b1;
                                nxt_wr = 1'b0;
                                nxt_done = 1'b0;
                                nxt_busy = 1'b1;
                                nxt_state = st_pointer;
                            end
                        end
                        md_indirect16: begin
                            nxt_xram_addr = data_pointer;
                            nxt_xram_sel = 1'b1;
                        end
                        md_register: begin
                            nxt_iram_addr = {bank_base[7:3],
                                             opcode[2:0]};
                            nxt_iram_sel = 1'b1;
                        end
                        md_implicit: begin
                            nxt_implicit = 1'b1;
                        end
                        md_immediate: begin
                            nxt_code_addr = prog_counter +
                                            `SWA_PC_STEP;
                            nxt_code_rd = 1'b1;
                            nxt_wr = 1'b0;
                        end
                        md_indexed: begin
                            nxt_code_addr = idx_sum;
                            nxt_code_rd = 1'b1;
                            nxt_wr = 1'b0;
                        end
                        md_case_jump: begin
                            nxt_pc_next = idx_sum;
                            nxt_pc_load = 1'b1;
                            nxt_wr = 1'b0;
                        end
                    endcase
                end
            end
            st_pointer: begin
                // Register file answers one cycle after the read
                nxt_iram_addr = ram_rd_data;
                nxt_iram_sel = !ext_ff;
                nxt_xram_addr = {8'h00, ram_rd_data};
                nxt_xram_sel = ext_ff;
                nxt_wr = operand_write;
                nxt_done = 1'b1;
                nxt_busy = 1'b0;
                nxt_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= st_idle;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            iram_addr_ff <= 8'h00;
            iram_sel_ff <= 1'b0;
            sfr_sel_ff <= 1'b0;
            xram_addr_ff <= 16'h0000;
            xram_sel_ff <= 1'b0;
            code_addr_ff <= 16'h0000;
            code_rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            ext_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_next_ff <= 16'h0000;
            implicit_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            iram_addr_ff <= nxt_iram_addr;
            iram_sel_ff <= nxt_iram_sel;
            sfr_sel_ff <= nxt_sfr_sel;
            xram_addr_ff <= nxt_xram_addr;
            xram_sel_ff <= nxt_xram_sel;
            code_addr_ff <= nxt_code_addr;
            code_rd_ff <= nxt_code_rd;
            wr_ff <= nxt_wr;
            ext_ff <= nxt_ext;
            pc_load_ff <= nxt_pc_load;
            pc_next_ff <= nxt_pc_next;
            implicit_ff <= nxt_implicit;
        end
    end

    assign program_status_word = psw_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign iram_addr = iram_addr_ff;
    assign iram_sel = iram_sel_ff;
    assign sfr_sel = sfr_sel_ff;
    assign xram_addr = xram_addr_ff;
    assign xram_sel = xram_sel_ff;
    assign code_addr = code_addr_ff;
    assign code_rd = code_rd_ff;
    // Write strobe masked whenever code space is the target
    assign oper_wr_en = wr_ff && !code_rd_ff && !pc_load_ff;
    assign pc_load = pc_load_ff;
    assign pc_next = pc_next_ff;
    assign implicit_sel = implicit_ff;

    logic start_ok;
    assign start_ok = ce && instr_start && state_ff == st_idle;

    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Pointer cycle follows the start directly while ce stays high
    sequence s_ptr_fetch;
        start_ok && instr_mode == md_indirect8 && !ind_use_sp
        ##1 ce && state_ff == st_pointer;
    endsequence

    a_parity_odd: assert property (
        ce |=> psw_ff[0] == ^$past(acc))
        else $error("parity bit does not follow accumulator");
    a_parity_write: assert property (
        ce && sfr_wr_en && sfr_wr_data[0] != ^acc
        |=> psw_ff[0] != $past(sfr_wr_data[0]))
        else $error("software write overrode parity bit");
    a_carry_bool: assert property (
        ce && bool_carry_we |=> psw_ff[7] == $past(bool_carry))
        else $error("carry not loaded from Boolean result");
    a_half_carry: assert property (
        ce && alu_flag_we |=> psw_ff[6] == $past(alu_half_carry))
        else $error("half-carry not loaded");
    a_user_keep: assert property (
        !sfr_wr_en |=> $stable(psw_ff[5]))
        else $error("user flag changed without a write");
    a_bank_write: assert property (
        ce && sfr_wr_en |=> bank == $past(sfr_wr_data[4:3]))
        else $error("bank select not written");
    a_reg_bank: assert property (
        start_ok && instr_mode == md_register
        |=> iram_addr == {3'h0, $past(bank), $past(opcode[2:0])}
            && iram_sel && done)
        else $error("register operand address wrong");
    a_ovf_rsv: assert property (
        ce && alu_flag_we |=> psw_ff[2] == $past(alu_overflow)
            && !psw_ff[1])
        else $error("overflow or reserved bit wrong");
    a_direct_sfr: assert property (
        start_ok && instr_mode == md_direct
        |=> iram_addr == $past(addr_byte)
            && sfr_sel == $past(addr_byte[7]))
        else $error("direct address or space wrong");
    a_ptr_indirect: assert property (
        s_ptr_fetch |=> done && (iram_sel || xram_sel)
            && iram_addr == $past(ram_rd_data))
        else $error("indirect pointer not applied");
    a_data_pointer_ind: assert property (
        start_ok && instr_mode == md_indirect16
        |=> xram_sel && xram_addr == $past(data_pointer))
        else $error("16-bit indirect address wrong");
    a_immediate: assert property (
        start_ok && instr_mode == md_immediate
        |=> code_rd && code_addr == $past(prog_counter) + 16'h0001)
        else $error("immediate fetch address wrong");
    a_indexed_rd: assert property (
        start_ok && instr_mode == md_indexed
        |=> code_rd && !oper_wr_en && code_addr == 16'($past(
            idx_base_pc ? prog_counter : data_pointer) + $past(acc)))
        else $error("indexed read wrong or write raised");
    // A frozen clock or a second case jump keeps the pulse up
    a_case_jump: assert property (
        start_ok && instr_mode == md_case_jump
        |=> pc_load && pc_next == 16'($past(data_pointer) + $past(acc))
        ##1 (!pc_load || $past(!ce || (start_ok
            && instr_mode == md_case_jump))))
        else $error("case jump target wrong");

endmodule

// ===== swa_core_tb.sv
// Self-checking testbench for the status word and operand address block
`timescale 1ns/1ps
module swa_core_tb;
    import swa_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] acc = 8'h00;
    logic sfr_wr_en = 1'b0;
    logic [7:0] sfr_wr_data = 8'h00;
    logic [7:0] program_status_word;
    logic alu_flag_we = 1'b0;
    logic alu_carry = 1'b0;
    logic alu_half_carry = 1'b0;
    logic alu_overflow = 1'b0;
    logic bool_carry_we = 1'b0;
    logic bool_carry = 1'b0;
    logic instr_start = 1'b0;
    swa_mode_type instr_mode = md_direct;
    logic [7:0] opcode = 8'h00;
    logic [7:0] addr_byte = 8'h00;
    logic ind_use_sp = 1'b0;
    logic ind_external = 1'b0;
    logic idx_base_pc = 1'b0;
    logic operand_write = 1'b0;
    logic [7:0] stack_pointer = 8'h30;
    logic [15:0] data_pointer = 16'hFFF0;
    logic [15:0] prog_counter = 16'h1234;
    logic [7:0] ram_rd_data = 8'h42;
    logic busy, done, iram_sel, sfr_sel, xram_sel, code_rd;
    logic oper_wr_en, pc_load, implicit_sel;
    logic [7:0] iram_addr;
    logic [15:0] xram_addr, code_addr, pc_next;
    int num_errors = 0;
    int total_checks = 0;
    logic first_busy;
    logic [7:0] first_addr;
    logic [7:0] par_vals [6] = '{8'h01, 8'h03, 8'h80, 8'h7F, 8'hFE, 8'h00};
    int lat;

    swa_core dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .acc(acc),
        .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data),
        .program_status_word(program_status_word),
        .alu_flag_we(alu_flag_we), .alu_carry(alu_carry),
        .alu_half_carry(alu_half_carry), .alu_overflow(alu_overflow),
        .bool_carry_we(bool_carry_we), .bool_carry(bool_carry),
        .instr_start(instr_start), .instr_mode(instr_mode),
        .opcode(opcode), .addr_byte(addr_byte), .ind_use_sp(ind_use_sp),
        .ind_external(ind_external), .idx_base_pc(idx_base_pc),
        .operand_write(operand_write), .stack_pointer(stack_pointer),
        .data_pointer(data_pointer), .prog_counter(prog_counter),
        .ram_rd_data(ram_rd_data), .busy(busy), .done(done),
        .iram_addr(iram_addr), .iram_sel(iram_sel), .sfr_sel(sfr_sel),
        .xram_addr(xram_addr), .xram_sel(xram_sel), .code_addr(code_addr),
        .code_rd(code_rd), .oper_wr_en(oper_wr_en), .pc_load(pc_load),
        .pc_next(pc_next), .implicit_sel(implicit_sel));

    always #50 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected readback: bit one reads zero, bit zero follows acc
    function automatic logic [7:0] exp_psw(input logic [7:0] d);
        return {d[7:2], 1'b0, ^acc};
    endfunction

    task automatic wr_psw(input logic [7:0] d);
        @(posedge ref_clk);
        sfr_wr_en <= 1'b1;
        sfr_wr_data <= d;
        @(posedge ref_clk);
        sfr_wr_en <= 1'b0;
        #1;
    endtask

    // Flags: {operand_write, ind_use_sp, ind_external, idx_base_pc}
    task automatic exec(input swa_mode_type m, input logic [7:0] op,
                        input logic [7:0] ab, input logic [3:0] fl);
        @(posedge ref_clk);
        instr_mode <= m;
        opcode <= op;
        addr_byte <= ab;
        {operand_write, ind_use_sp, ind_external, idx_base_pc} <= fl;
        instr_start <= 1'b1;
        @(posedge ref_clk);
        instr_start <= 1'b0;
        #1;
        first_busy = busy;
        first_addr = iram_addr;
        lat = 1;
        // Bounded wait so a missing completion cannot hang the run
        while (done !== 1'b1 && lat < 8) begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
        chk(16'(done), 16'h0001);
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        num_errors++;
        stop_test;
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(16'(program_status_word), 16'h0000);
        chk(16'({done, pc_load, busy}), 16'h0000);
        $display("test reset done");

        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            acc <= par_vals[i];
            @(posedge ref_clk);
            @(posedge ref_clk);
            #1;
            chk(16'(program_status_word[0]), 16'(^acc));
        end
        $display("test parity done");

        @(posedge ref_clk);
        acc <= 8'h01;
        wr_psw(8'hFF);
        chk(16'(program_status_word), 16'(exp_psw(8'hFF)));
        wr_psw(8'h20);
        chk(16'(program_status_word), 16'(exp_psw(8'h20)));
        // Software, arithmetic and Boolean updates all in one cycle
        @(posedge ref_clk);
        {sfr_wr_en, sfr_wr_data} <= {1'b1, 8'h00};
        {alu_flag_we, alu_carry, alu_half_carry, alu_overflow} <= 4'hF;
        {bool_carry_we, bool_carry} <= 2'b10;
        @(posedge ref_clk);
        {sfr_wr_en, alu_flag_we, bool_carry_we} <= 3'b000;
        #1;
        chk(16'(program_status_word), 16'(exp_psw(8'h44)));
        wr_psw(8'h20);
        @(posedge ref_clk);
        {alu_flag_we, alu_carry, alu_half_carry, alu_overflow} <= 4'b1100;
        @(posedge ref_clk);
        alu_flag_we <= 1'b0;
        {bool_carry_we, bool_carry} <= 2'b11;
        @(posedge ref_clk);
        bool_carry_we <= 1'b0;
        #1;
        chk(16'(program_status_word), 16'(exp_psw(8'hA0)));
        // Clock enable low must freeze the register
        @(posedge ref_clk);
        ce <= 1'b0;
        wr_psw(8'h18);
        chk(16'(program_status_word), 16'(exp_psw(8'hA0)));
        @(posedge ref_clk);
        ce <= 1'b1;
        $display("test status word done");

        for (int b = 0; b < 4; b++) begin
            wr_psw(8'(b << 3));
            chk(16'(program_status_word[4:3]), 16'(b));
            exec(md_register, 8'h05, 8'h00, 4'h0);
            chk(16'({iram_sel, iram_addr}), 16'(261+8*b));
        end
        $display("test register bank done");

        exec(md_direct, 8'h00, 8'h7F, 4'h8);
        chk(16'({sfr_sel, iram_sel, iram_addr}), 16'h017F);
        chk(16'(oper_wr_en), 16'h0001);
        exec(md_direct, 8'h00, 8'hD0, 4'h0);
        chk(16'(sfr_sel), 16'h0001);
        $display("test direct done");

        wr_psw(8'h18);
        exec(md_indirect8, 8'h01, 8'h00, 4'h0);
        chk(16'({first_busy, 7'(lat)}), 16'h0082);
        chk(16'(first_addr), 16'h0019);
        chk(16'({iram_sel, iram_addr}), 16'h0142);
        exec(md_indirect8, 8'h00, 8'h00, 4'h2);
        chk(16'(xram_addr), 16'h0042);
        chk(16'(xram_sel), 16'h0001);
        exec(md_indirect8, 8'h00, 8'h00, 4'h4);
        chk(16'({iram_sel, iram_addr}), 16'h0130);
        exec(md_indirect16, 8'h00, 8'h00, 4'h0);
        chk(xram_addr, data_pointer);
        chk(16'(xram_sel), 16'h0001);
        $display("test indirect done");

        exec(md_implicit, 8'h00, 8'h00, 4'h0);
        chk(16'(implicit_sel), 16'h0001);
        exec(md_immediate, 8'h00, 8'h00, 4'h0);
        chk(code_addr, 16'h1235);
        chk(16'(code_rd), 16'h0001);
        @(posedge ref_clk);
        acc <= 8'h20;
        exec(md_indexed, 8'h00, 8'h00, 4'h8);
        chk(code_addr, 16'h0010);
        chk(16'({code_rd, oper_wr_en}), 16'h0002);
        exec(md_indexed, 8'h00, 8'h00, 4'h9);
        chk(code_addr, 16'h1254);
        chk(16'(oper_wr_en), 16'h0000);
        exec(md_case_jump, 8'h00, 8'h00, 4'h0);
        chk(16'(pc_load), 16'h0001);
        chk(pc_next, 16'h0010);
        @(posedge ref_clk);
        #1;
        chk(16'(pc_load), 16'h0000);
        $display("test indexed done");
        stop_test;
    end
endmodule
